// ### vgpc_defines.svh
`ifndef VGPC_DEFINES_SVH
`define VGPC_DEFINES_SVH

// ----------------------------------------
// Timing, minimum counts and result width
// ----------------------------------------
`define VGPC_CLK_PERIOD_NS 5
`define VGPC_PD_TIME_US 1000
`define VGPC_PD_CYCLES ((`VGPC_PD_TIME_US * 1000) / `VGPC_CLK_PERIOD_NS)
`define VGPC_MCLK_HZ 1000000
`define VGPC_GATE_TIME_MS 100
`define VGPC_GATE_MCLKS ((`VGPC_MCLK_HZ / 1000) * `VGPC_GATE_TIME_MS)
`define VGPC_MIN_COUNTS 4096
`define VGPC_RESULT_BITS 12

// ----------------------------------------
// Rate scale, in tenths of the master clock
// ----------------------------------------
`define VGPC_RATE_MIN 4'h1
`define VGPC_RATE_MAX 4'h9
`define VGPC_RATE_DEN 4'hA

`endif

// ### vgpc_pkg.sv
package vgpc_pkg;
  typedef enum logic [0:0] {
    VGPC_RUN = 1'b0,
    VGPC_PWRDN = 1'b1
  } vgpc_mode_t;

  typedef enum logic [0:0] {
    VGPC_GATE_OPEN = 1'b0,
    VGPC_GATE_SHUT = 1'b1
  } vgpc_gate_t;
endpackage

// ### vgpc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vgpc_link_if;
  logic master_clock_in;
  logic inverted_clock_out;
  logic pulse_train_out;
  logic reference_out;
  logic reference_out_oe;

  modport converter (
    input master_clock_in,
    output inverted_clock_out,
    output pulse_train_out,
    output reference_out,
    output reference_out_oe
  );

  modport counter (
    output master_clock_in,
    input inverted_clock_out,
    input pulse_train_out,
    input reference_out,
    input reference_out_oe
  );
endinterface
`default_nettype wire

// ### vgpc_converter.sv
// Functional notes
// - Clock out is inverted master clock
// - Master clock low 1 ms: power down
// - Power down: reference floats, pulses high
// - Gate from divide-by-GATE_MCLKS counter of master clock
// - Count pulse rising edges while gate high
// - Result may be off by one count
// - Gate gives at least 4096 full-scale counts
// - Full scale rate 0.9 of master clock
// - Gate spans whole interference periods, 100 ms
// - Pulse one high phase, rising-edge aligned
// - Rate 0.1 to 0.9 of master clock
`timescale 1ns/1ps
`default_nettype none
`include "vgpc_defines.svh"
module vgpc_converter #(
  parameter int PD_CYCLES = `VGPC_PD_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  input wire logic [3:0] rate_tenths,
  output logic powered_down,
  vgpc_link_if.converter link
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  initial
  begin
    if (PD_CYCLES < 2)
    begin
      $error("PD_CYCLES too small");
    end
    if (`VGPC_RATE_MIN < 4'h1)
    begin
      $error("Rate floor must be nonzero");
    end
    if (`VGPC_RATE_MAX >= `VGPC_RATE_DEN)
    begin
      $error("Rate ceiling must stay below scale");
    end
  end

  localparam int CW = $clog2(PD_CYCLES + 1);

  // ----------------------------------------
  // Master clock sampling and idle detect
  // ----------------------------------------
  logic mclk_q;
  logic next_mclk_q;
  logic [CW-1:0] idle_cnt;
  logic [CW-1:0] next_idle_cnt;
  vgpc_pkg::vgpc_mode_t mode;
  vgpc_pkg::vgpc_mode_t next_mode;
  logic pd;
  logic next_pd;

  // ----------------------------------------
  // Pulse generation state
  // ----------------------------------------
  logic clk_out;
  logic next_clk_out;
  logic pulse;
  logic next_pulse;
  logic ref_oe;
  logic next_ref_oe;
  logic [3:0] acc;
  logic [3:0] next_acc;
  logic [3:0] rate;
  logic mclk_rise;
  logic [4:0] sum;

  // ----------------------------------------
  // Rate clamp
  // ----------------------------------------

  always_comb
  begin
    if (rate_tenths < `VGPC_RATE_MIN)
    begin
      rate = `VGPC_RATE_MIN;
    end
    else if (rate_tenths > `VGPC_RATE_MAX)
    begin
      rate = `VGPC_RATE_MAX;
    end
    else
    begin
      rate = rate_tenths;
    end
  end

  // ----------------------------------------
  // Derived terms
  // ----------------------------------------
  assign mclk_rise = link.master_clock_in & ~mclk_q;
  assign sum = {1'b0, acc} + {1'b0, rate};

  // ----------------------------------------
  // Idle detect and mode
  // ----------------------------------------
  always_comb
  begin
    next_mclk_q = link.master_clock_in;
    next_idle_cnt = idle_cnt;
    next_mode = mode;
    if (link.master_clock_in)
    begin
      next_idle_cnt = '0;
      next_mode = vgpc_pkg::VGPC_RUN;
    end
    else if (idle_cnt < CW'(PD_CYCLES))
    begin
      next_idle_cnt = idle_cnt + CW'(1);
    end
    else
    begin
      next_mode = vgpc_pkg::VGPC_PWRDN;
    end
    next_pd = (next_mode == vgpc_pkg::VGPC_PWRDN);
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      mclk_q <= 1'b0;
      idle_cnt <= '0;
      mode <= vgpc_pkg::VGPC_RUN;
      pd <= 1'b0;
    end
    else if (clock_en)
    begin
      mclk_q <= next_mclk_q;
      idle_cnt <= next_idle_cnt;
      mode <= next_mode;
      pd <= next_pd;
    end
  end

  // ----------------------------------------
  // Pulse train, clock out, reference enable
  // ----------------------------------------
  always_comb
  begin
    next_clk_out = ~link.master_clock_in;
    next_pulse = pulse;
    next_acc = acc;
    next_ref_oe = ref_oe;
    case (next_mode)
      vgpc_pkg::VGPC_PWRDN:
      begin
        next_pulse = 1'b1;
        next_ref_oe = 1'b0;
        next_acc = '0;
      end
      vgpc_pkg::VGPC_RUN:
      begin
        next_ref_oe = 1'b1;
        if (mclk_rise)
        begin
          if (sum >= {1'b0, `VGPC_RATE_DEN})
          begin
            next_acc = 4'(sum - {1'b0, `VGPC_RATE_DEN});
            next_pulse = 1'b1;
          end
          else
          begin
            next_acc = sum[3:0];
            next_pulse = 1'b0;
          end
        end
        else if (!link.master_clock_in)
        begin
          next_pulse = 1'b0;
        end
      end
      default:
      begin
        next_pulse = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      clk_out <= 1'b1;
      pulse <= 1'b0;
      acc <= 4'h0;
      ref_oe <= 1'b0;
    end
    else if (clock_en)
    begin
      clk_out <= next_clk_out;
      pulse <= next_pulse;
      acc <= next_acc;
      ref_oe <= next_ref_oe;
    end
  end

  // ----------------------------------------
  // Link outputs and power-down flag
  // ----------------------------------------
  assign link.inverted_clock_out = clk_out;
  assign link.pulse_train_out = pulse;
  assign link.reference_out = 1'b1;
  assign link.reference_out_oe = ref_oe;
  assign powered_down = pd;

endmodule
`default_nettype wire

// ### vgpc_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "vgpc_defines.svh"
module vgpc_counter #(
  parameter int HALF_DIV = 100,
  parameter int GATE_MCLKS = `VGPC_GATE_MCLKS,
  parameter int RESULT_BITS = 24
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  output logic gate,
  output logic [RESULT_BITS-1:0] result,
  output logic result_valid,
  vgpc_link_if.counter link
);

  initial
  begin
    if (HALF_DIV < 1 || GATE_MCLKS < 2 || RESULT_BITS < `VGPC_RESULT_BITS)
    begin
      $error("Bad counter parameters");
    end
    if ((1 << RESULT_BITS) <= GATE_MCLKS)
    begin
      $error("Result too narrow for gate");
    end
  end

  localparam int HW = $clog2(HALF_DIV + 1);
  localparam int GW = $clog2(2 * GATE_MCLKS + 1);

  // ----------------------------------------
  // Master clock and gate divider
  // ----------------------------------------
  logic [HW-1:0] hcnt;
  logic [HW-1:0] next_hcnt;
  logic mclk;
  logic next_mclk;
  logic [GW-1:0] div;
  logic [GW-1:0] next_div;
  vgpc_pkg::vgpc_gate_t gst;
  vgpc_pkg::vgpc_gate_t next_gst;
  logic pulse_train_out_q;
  logic next_pulse_train_out_q;
  logic [RESULT_BITS-1:0] cnt;
  logic [RESULT_BITS-1:0] next_cnt;
  logic [RESULT_BITS-1:0] next_result;
  logic next_valid;
  logic mrise;

  assign mrise = (hcnt == HW'(HALF_DIV - 1)) & ~mclk;

  always_comb
  begin
    next_hcnt = hcnt + HW'(1);
    next_mclk = mclk;
    next_div = div;
    next_gst = gst;
    next_pulse_train_out_q = link.pulse_train_out;
    next_cnt = cnt;
    next_result = result;
    next_valid = 1'b0;
    if (hcnt == HW'(HALF_DIV - 1))
    begin
      next_hcnt = '0;
      next_mclk = ~mclk;
    end
    if (mrise)
    begin
      if (div == GW'(GATE_MCLKS - 1))
      begin
        next_div = '0;
        case (gst)
          vgpc_pkg::VGPC_GATE_OPEN:
          begin
            next_gst = vgpc_pkg::VGPC_GATE_SHUT;
          end
          vgpc_pkg::VGPC_GATE_SHUT:
          begin
            next_gst = vgpc_pkg::VGPC_GATE_OPEN;
          end
          default:
          begin
            next_gst = vgpc_pkg::VGPC_GATE_SHUT;
          end
        endcase
      end
      else
      begin
        next_div = div + GW'(1);
      end
    end
    if (gst == vgpc_pkg::VGPC_GATE_OPEN && link.pulse_train_out && !pulse_train_out_q)
    begin
      next_cnt = cnt + RESULT_BITS'(1);
    end
    if (gst == vgpc_pkg::VGPC_GATE_OPEN && next_gst == vgpc_pkg::VGPC_GATE_SHUT)
    begin
      next_result = next_cnt;
      next_valid = 1'b1;
    end
    if (gst == vgpc_pkg::VGPC_GATE_SHUT)
    begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      hcnt <= '0;
      mclk <= 1'b0;
      div <= '0;
      gst <= vgpc_pkg::VGPC_GATE_SHUT;
      pulse_train_out_q <= 1'b1;
      cnt <= '0;
      result <= '0;
      result_valid <= 1'b0;
      gate <= 1'b0;
    end
    else if (clock_en)
    begin
      hcnt <= next_hcnt;
      mclk <= next_mclk;
      div <= next_div;
      gst <= next_gst;
      pulse_train_out_q <= next_pulse_train_out_q;
      cnt <= next_cnt;
      result <= next_result;
      result_valid <= next_valid;
      gate <= (next_gst == vgpc_pkg::VGPC_GATE_OPEN);
    end
  end

  assign link.master_clock_in = mclk;

endmodule
`default_nettype wire

// ### vgpc_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vgpc_link_checker #(
  parameter int PD_CYCLES = 50,
  parameter int HALF_DIV = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic conv_en,
  input wire logic master_clock_in,
  input wire logic inverted_clock_out,
  input wire logic pulse_train_out,
  input wire logic reference_out_oe
);
  // ----------------------------------------
  // Run lengths of master clock levels
  // ----------------------------------------
  int low_cnt;
  int hi_len;
  int next_low_cnt;
  int next_hi_len;
  always_comb
  begin
    next_low_cnt = master_clock_in ? 0 : low_cnt + 1;
    next_hi_len = master_clock_in ? hi_len + 1 : 0;
  end
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      low_cnt <= 0;
      hi_len <= 0;
    end
    else if (conv_en)
    begin
      low_cnt <= next_low_cnt;
      hi_len <= next_hi_len;
    end
  end
  // ----------------------------------------
  // Link assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn || !conv_en);
  sequence mclk_rise;
    !master_clock_in ##1 master_clock_in;
  endsequence
  inv_clock_a: assert property (
    $past(rstn) && $past(conv_en) |-> inverted_clock_out == !$past(master_clock_in))
    else $error("Clock out not inverted");
  pulse_rise_a: assert property (
    $rose(pulse_train_out) && reference_out_oe
    |-> $past(master_clock_in) && !$past(master_clock_in, 2))
    else $error("Pulse not aligned to master rise");
  pulse_fall_a: assert property (
    $fell(master_clock_in) && pulse_train_out && reference_out_oe |=> !pulse_train_out)
    else $error("Pulse outlasts master high phase");
  pd_pulse_a: assert property (
    !reference_out_oe && $past(rstn) |-> pulse_train_out)
    else $error("Pulse not high in power down");
  pd_entry_a: assert property (
    low_cnt == PD_CYCLES |-> ##[0:3] !reference_out_oe)
    else $error("Power down not entered");
  pd_early_a: assert property (
    $fell(reference_out_oe) |-> low_cnt >= PD_CYCLES - 3)
    else $error("Power down entered early");
  pd_exit_a: assert property (
    mclk_rise |-> ##[0:2] reference_out_oe)
    else $error("Power down not left");
  mclk_high_a: assert property (
    $fell(master_clock_in) |-> hi_len == HALF_DIV)
    else $error("Master high phase wrong length");
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic en_cnt = 1'b1;
  logic en_conv = 1'b1;
  logic [3:0] rate = 4'h9;
  logic powered_down;
  logic gate;
  logic result_valid;
  logic [23:0] result;
  logic [23:0] got;
  logic mclk_seen;
  logic [3:0] rates [5] = '{4'h1, 4'h9, 4'h5, 4'h0, 4'hF};
  int bad_count = 0;
  int checked = 0;
  vgpc_link_if link ();
  always #2.5 clock = ~clock;
  vgpc_converter #(.PD_CYCLES(50)) i_vgpc_converter (.clock(clock), .rstn(rstn),
    .clock_en(en_conv), .rate_tenths(rate), .powered_down(powered_down), .link(link));
  vgpc_counter #(.HALF_DIV(2), .GATE_MCLKS(50)) i_vgpc_counter (.clock(clock),
    .rstn(rstn), .clock_en(en_cnt), .gate(gate), .result(result),
    .result_valid(result_valid), .link(link));
  vgpc_link_checker #(.PD_CYCLES(50), .HALF_DIV(2)) i_vgpc_link_checker (.clock(clock),
    .rstn(rstn), .conv_en(en_conv), .master_clock_in(link.master_clock_in),
    .inverted_clock_out(link.inverted_clock_out),
    .pulse_train_out(link.pulse_train_out), .reference_out_oe(link.reference_out_oe));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input int tol);
    checked++;
    if (!(seen === exp || (tol > 0 && (seen === exp + 24'h1 || seen === exp - 24'h1))))
    begin
      bad_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic read_result(output logic [23:0] val);
    int n;
    n = 0;
    @(negedge clock);
    while (result_valid !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    val = result;
    check({23'h0, result_valid}, 24'h1, 0);
    check({23'h0, gate}, 24'h0, 0);
    @(negedge clock);
    check({23'h0, result_valid}, 24'h0, 0);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    repeat (8)
    begin
      @(negedge clock);
      mclk_seen = link.master_clock_in;
      @(negedge clock);
      check({23'h0, link.inverted_clock_out}, {23'h0, ~mclk_seen}, 0);
    end
    foreach (rates[i])
    begin
      rate = rates[i];
      read_result(got);
      read_result(got);
      check(got, 24'(50 * (rates[i] < 1 ? 1 : rates[i] > 9 ? 9 : rates[i]) / 10), 1);
    end
    while (link.master_clock_in !== 1'b0) @(negedge clock);
    en_cnt = 1'b0;
    en_conv = 1'b0;
    repeat (60) @(negedge clock);
    check({22'h0, powered_down, link.reference_out_oe}, 24'h1, 0);
    en_conv = 1'b1;
    repeat (60) @(negedge clock);
    check({21'h0, powered_down, link.pulse_train_out, link.reference_out_oe}, 24'h6, 0);
    en_cnt = 1'b1;
    repeat (10) @(negedge clock);
    check({21'h0, powered_down, link.reference_out_oe, link.reference_out}, 24'h3, 0);
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
